// file: common/rsc_pkg.sv
package rsc_pkg;

  // ==========================================
  // clock and timing
  localparam int CLK_MHZ = 50;
  // shortest time a reset is held internally
  localparam int HOLD_NS = 100;
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS * CLK_MHZ + 999) / 1000);
  // system clock gap that counts as a missing clock
  localparam int MISSCLK_TIMEOUT_NS = 500;
  localparam logic [5:0] MISSCLK_CYC = 6'((MISSCLK_TIMEOUT_NS * CLK_MHZ + 999) / 1000);
  localparam int WDOG_DIV = 12;
  localparam logic [3:0] WDOG_DIV_LAST = 4'(WDOG_DIV - 1);

  // ==========================================
  // register map
  localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'hFF;
  localparam logic [7:0] ADDR_RESET_SRC = 8'hEF;
  localparam int BIT_SUP_EN = 7;
  localparam int BIT_SUP_STAT = 6;
  localparam int BIT_PIN = 0;
  localparam int BIT_POR = 1;
  localparam int BIT_MISSCLK = 2;
  localparam int BIT_WDOG = 3;
  localparam int BIT_SW = 4;
  localparam int BIT_CMP = 5;
  localparam int BIT_FERR = 6;
  localparam logic [15:0] CODE_LIMIT = 16'h3DFF;

  // ==========================================
  // values after power-on
  localparam logic SUP_EN_POR = 1'b1;
  localparam logic SUP_SEL_POR = 1'b1;
  localparam logic [6:0] FLAGS_POR = 7'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ==========================================
  // types
  typedef enum {CAUSE_POR, CAUSE_SUPPLY, CAUSE_PIN, CAUSE_MISSCLK,
                CAUSE_CMP, CAUSE_WDOG, CAUSE_FERR, CAUSE_SW} cause_t;
  typedef enum {ST_RUN, ST_HOLD, ST_RELEASE} state_t;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } mem_req_t;
  typedef struct packed {
    logic ferr;
    logic cmp;
    logic sw;
    logic wdog;
    logic missClk;
    logic por;
    logic pin;
  } flags_t;

endpackage

// file: logic/reset_source_controller.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - supply reset needs enable and selection
// - supply enable set by power-on, else sticky
// - status bit 6 shows live supply
// - control bits 5:0 ignored, read zero
// - low reset pin holds device in reset
// - pin reset sets bit 0 on exit
// - stalled system clock triggers missing-clock reset
// - bit 2 reads 1 only after missing-clock
// - bit 2 write enables or disables detector
// - resets other than power-on and supply leave reset pin undriven
// - bit 5 write 1 enables comparator reset
// - low comparator output resets when enabled
// - comparator flag set only after comparator reset
// - every reset re-enables watchdog, clock /12
// - watchdog expiry resets and sets flag
// - flash write above limit gives error
// - code read above limit gives error
// - fetch above limit gives error
// - security-forbidden flash access gives error
// - flash error reset sets bit 6
// - bit 4 write forces reset, reads 1
// - bit 1 power flag, write selects monitor
// - bit 3 read-only watchdog flag
module reset_source_controller (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic supplyAboveRaw,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe,
  input wire logic sysClkIn,
  input wire logic comparatorOutRaw,
  input wire logic watchdogExpired,
  input wire logic flashWriteEnable,
  input wire rsc_pkg::mem_req_t dataMoveWrite,
  input wire rsc_pkg::mem_req_t codeRead,
  input wire rsc_pkg::mem_req_t fetch,
  input wire logic flashSecurityFault,
  output logic systemReset,
  output logic watchdogForceOn,
  output logic watchdogTick,
  output logic supplyMonitorOn
);

  // ==========================================
  // synchronisers
  logic [3:0] asyncRaw;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic supplyOk;
  logic pinHigh;
  logic cmpHigh;
  logic sysClkS;

  assign asyncRaw = {sysClkIn, comparatorOutRaw, resetPinIn, supplyAboveRaw};

  // idle-high reset value keeps a fresh power-on from seeing false trips
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_r <= 4'hF;
      sync2_r <= 4'hF;
    end else begin
      sync1_r <= asyncRaw;
      sync2_r <= sync1_r;
    end
  end

  assign supplyOk = sync2_r[0];
  assign pinHigh = sync2_r[1];
  assign cmpHigh = sync2_r[2];
  assign sysClkS = sync2_r[3];

  // ==========================================
  // state
  rsc_pkg::state_t state_r;
  rsc_pkg::cause_t cause_r;
  rsc_pkg::cause_t causeNxt;
  rsc_pkg::flags_t flags_r;
  logic [3:0] holdCnt_r;
  logic supEn_r;
  logic supSel_r;
  logic missClkEn_r;
  logic cmpEn_r;
  logic sysClkPrev_r;
  logic [5:0] missClkCnt_r;
  logic [3:0] wdogDiv_r;
  logic wdogTick_r;
  logic [7:0] sfrRdata_r;

  logic running;
  logic wrCtrl;
  logic wrSrc;
  logic supplyTrip;
  logic pinTrip;
  logic missClkTimedOut;
  logic missClkTrip;
  logic cmpTrip;
  logic wdogTrip;
  logic ferrTrip;
  logic swTrip;
  logic anyTrip;
  logic drivesPin;
  logic holdDone;
  logic exitOk;
  logic leaving;

  assign running = (state_r == rsc_pkg::ST_RUN);
  assign wrCtrl = running && sfrWrite && (sfrAddr == rsc_pkg::ADDR_SUPPLY_CTRL);
  assign wrSrc = running && sfrWrite && (sfrAddr == rsc_pkg::ADDR_RESET_SRC);

  function automatic logic overLimit(input rsc_pkg::mem_req_t req);
    overLimit = req.valid && (req.addr > rsc_pkg::CODE_LIMIT);
  endfunction

  // ==========================================
  // reset causes
  assign supplyTrip = supEn_r && supSel_r && !supplyOk;
  assign pinTrip = !pinHigh;
  assign missClkTimedOut = (missClkCnt_r >= rsc_pkg::MISSCLK_CYC);
  assign missClkTrip = missClkEn_r && missClkTimedOut;
  assign cmpTrip = cmpEn_r && !cmpHigh;
  assign wdogTrip = watchdogExpired;
  assign ferrTrip = (flashWriteEnable && overLimit(dataMoveWrite))
    || overLimit(codeRead)
    || overLimit(fetch)
    || flashSecurityFault;
  assign swTrip = wrSrc && sfrWdata[rsc_pkg::BIT_SW];
  assign anyTrip = supplyTrip || pinTrip || missClkTrip || cmpTrip
    || wdogTrip || ferrTrip || swTrip;

  // supply failure outranks everything since it also drives the pin
  always_comb begin
    if (supplyTrip) begin
      causeNxt = rsc_pkg::CAUSE_SUPPLY;
    end else if (pinTrip) begin
      causeNxt = rsc_pkg::CAUSE_PIN;
    end else if (missClkTrip) begin
      causeNxt = rsc_pkg::CAUSE_MISSCLK;
    end else if (cmpTrip) begin
      causeNxt = rsc_pkg::CAUSE_CMP;
    end else if (wdogTrip) begin
      causeNxt = rsc_pkg::CAUSE_WDOG;
    end else if (ferrTrip) begin
      causeNxt = rsc_pkg::CAUSE_FERR;
    end else begin
      causeNxt = rsc_pkg::CAUSE_SW;
    end
  end

  // ==========================================
  // reset sequencing
  assign drivesPin = (cause_r == rsc_pkg::CAUSE_POR)
    || (cause_r == rsc_pkg::CAUSE_SUPPLY);
  assign holdDone = (holdCnt_r >= rsc_pkg::HOLD_CYC);

  // level causes stay in reset until their source recovers
  always_comb begin
    unique case (cause_r)
      rsc_pkg::CAUSE_POR, rsc_pkg::CAUSE_SUPPLY: exitOk = supplyOk;
      rsc_pkg::CAUSE_PIN: exitOk = pinHigh;
      rsc_pkg::CAUSE_MISSCLK: exitOk = !missClkTimedOut;
      rsc_pkg::CAUSE_CMP: exitOk = cmpHigh;
      rsc_pkg::CAUSE_WDOG, rsc_pkg::CAUSE_FERR, rsc_pkg::CAUSE_SW: exitOk = 1'b1;
    endcase
  end

  assign leaving = ((state_r == rsc_pkg::ST_HOLD) && holdDone && exitOk && !drivesPin)
    || ((state_r == rsc_pkg::ST_RELEASE) && pinHigh);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= rsc_pkg::ST_HOLD;
      cause_r <= rsc_pkg::CAUSE_POR;
    end else begin
      unique case (state_r)
        rsc_pkg::ST_RUN: begin
          if (anyTrip) begin
            state_r <= rsc_pkg::ST_HOLD;
            cause_r <= causeNxt;
          end
        end
        rsc_pkg::ST_HOLD: begin
          if (holdDone && exitOk) begin
            state_r <= drivesPin ? rsc_pkg::ST_RELEASE : rsc_pkg::ST_RUN;
          end
        end
        rsc_pkg::ST_RELEASE: begin
          // our own drive must have let go of the pin before the core runs
          if (pinHigh) begin
            state_r <= rsc_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || running) begin
      holdCnt_r <= 4'h0;
    end else if (!holdDone) begin
      holdCnt_r <= holdCnt_r + 4'h1;
    end
  end

  // ==========================================
  // reset flags
  function automatic rsc_pkg::flags_t causeFlags(input rsc_pkg::cause_t c);
    causeFlags = '0;
    unique case (c)
      rsc_pkg::CAUSE_POR, rsc_pkg::CAUSE_SUPPLY: causeFlags.por = 1'b1;
      rsc_pkg::CAUSE_PIN: causeFlags.pin = 1'b1;
      rsc_pkg::CAUSE_MISSCLK: causeFlags.missClk = 1'b1;
      rsc_pkg::CAUSE_CMP: causeFlags.cmp = 1'b1;
      rsc_pkg::CAUSE_WDOG: causeFlags.wdog = 1'b1;
      rsc_pkg::CAUSE_FERR: causeFlags.ferr = 1'b1;
      rsc_pkg::CAUSE_SW: causeFlags.sw = 1'b1;
    endcase
  endfunction

  // flags change only on reset exit, so no software clear can race them
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flags_r <= rsc_pkg::FLAGS_POR;
    end else if (leaving) begin
      flags_r <= causeFlags(cause_r);
    end
  end

  // ==========================================
  // configuration bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      supEn_r <= rsc_pkg::SUP_EN_POR;
    end else if (wrCtrl) begin
      supEn_r <= sfrWdata[rsc_pkg::BIT_SUP_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      supSel_r <= rsc_pkg::SUP_SEL_POR;
    end else if (wrSrc) begin
      supSel_r <= sfrWdata[rsc_pkg::BIT_POR];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !running) begin
      missClkEn_r <= 1'b0;
    end else if (wrSrc) begin
      missClkEn_r <= sfrWdata[rsc_pkg::BIT_MISSCLK];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !running) begin
      cmpEn_r <= 1'b0;
    end else if (wrSrc) begin
      cmpEn_r <= sfrWdata[rsc_pkg::BIT_CMP];
    end
  end

  // ==========================================
  // missing-clock one-shot, retriggered by each system clock edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sysClkPrev_r <= 1'b1;
      missClkCnt_r <= 6'h00;
    end else begin
      sysClkPrev_r <= sysClkS;
      if (sysClkS != sysClkPrev_r) begin
        missClkCnt_r <= 6'h00;
      end else if (!missClkTimedOut) begin
        missClkCnt_r <= missClkCnt_r + 6'h01;
      end
    end
  end

  // ==========================================
  // watchdog defaults: prescaler restarts from zero after every reset
  always_ff @(posedge ref_clk) begin
    if (srst || !running || wdogDiv_r == rsc_pkg::WDOG_DIV_LAST) begin
      wdogDiv_r <= 4'h0;
    end else begin
      wdogDiv_r <= wdogDiv_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdogTick_r <= 1'b0;
    end else begin
      wdogTick_r <= running && (wdogDiv_r == rsc_pkg::WDOG_DIV_LAST);
    end
  end

  // ==========================================
  // register reads, one cycle after the address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sfrRdata_r <= rsc_pkg::RDATA_RST;
    end else begin
      unique case (sfrAddr)
        rsc_pkg::ADDR_SUPPLY_CTRL: sfrRdata_r <= {supEn_r, supplyOk, 6'h00};
        rsc_pkg::ADDR_RESET_SRC: sfrRdata_r <= {1'b0, flags_r};
        default: sfrRdata_r <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // outputs
  assign sfrRdata = sfrRdata_r;
  assign resetPinOut = 1'b0;
  assign resetPinOe = (state_r == rsc_pkg::ST_HOLD) && drivesPin;
  assign systemReset = !running;
  assign watchdogForceOn = !running;
  assign watchdogTick = wdogTick_r;
  assign supplyMonitorOn = supEn_r;

  // ==========================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_supply_gate: assert property (running && supplyTrip
    |=> state_r == rsc_pkg::ST_HOLD && cause_r == rsc_pkg::CAUSE_SUPPLY)
    else $error("supply trip not taken");
  a_enable_sticky: assert property (!running |=> $stable(supEn_r))
    else $error("supply enable changed in reset");
  a_status_live: assert property (sfrAddr == rsc_pkg::ADDR_SUPPLY_CTRL
    |=> sfrRdata[6] == $past(supplyOk) && sfrRdata[5:0] == 6'h00)
    else $error("supply status read wrong");
  a_pin_enter: assert property (running && pinTrip && !supplyTrip
    |=> cause_r == rsc_pkg::CAUSE_PIN ##0 systemReset)
    else $error("pin reset not taken");
  a_pin_flag: assert property (leaving && cause_r == rsc_pkg::CAUSE_PIN
    |=> flags_r == 7'h01)
    else $error("pin flag wrong");
  a_missclk_trip: assert property (running && missClkTrip |=> systemReset)
    else $error("missing clock ignored");
  a_flag_onehot: assert property (leaving |=> $onehot(flags_r))
    else $error("flags not one-hot");
  a_pin_undriven: assert property (!drivesPin |-> !resetPinOe)
    else $error("pin driven by internal reset");
  a_wdog_divide: assert property (watchdogTick
    |=> !watchdogTick [*8] ##1 !watchdogTick [*2])
    else $error("watchdog prescale wrong");
  a_flash_error: assert property (running && ferrTrip |=> systemReset)
    else $error("flash error ignored");
  a_soft_reset: assert property (running && swTrip |=> !running)
    else $error("software reset ignored");

  c_supply_reset: cover property (leaving && cause_r == rsc_pkg::CAUSE_SUPPLY);
  c_pin_reset: cover property (leaving && cause_r == rsc_pkg::CAUSE_PIN);
  c_cmp_reset: cover property (leaving && cause_r == rsc_pkg::CAUSE_CMP);
  c_soft_reset: cover property (running && swTrip);

endmodule
`default_nettype wire

// file: tb/ext_reset_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// external reset circuitry on the open-drain reset pin
module ext_reset_model (
  input wire logic assertReq,
  input wire logic pinOe,
  input wire logic pinOut,
  output logic pinLevel
);
  // the external pull-up wins only when nobody pulls low, so a released pin reads 1
  assign pinLevel = (assertReq || (pinOe && !pinOut)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// file: tb/reset_source_controller_tb.sv
`timescale 1ns/1ns
`default_nettype none
module reset_source_controller_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrite = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic supplyAboveRaw = 1'b1;
  logic resetPinIn;
  logic resetPinOut;
  logic resetPinOe;
  logic pinReq = 1'b0;
  logic sysClkIn = 1'b0;
  logic clkRun = 1'b1;
  logic comparatorOutRaw = 1'b1;
  logic watchdogExpired = 1'b0;
  logic flashWriteEnable = 1'b0;
  rsc_pkg::mem_req_t dataMoveWrite = '0;
  rsc_pkg::mem_req_t codeRead = '0;
  rsc_pkg::mem_req_t fetch = '0;
  logic flashSecurityFault = 1'b0;
  logic systemReset;
  logic watchdogForceOn;
  logic watchdogTick;
  logic supplyMonitorOn;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 94167;
  int kk;
  logic [7:0] rd;
  logic [15:0] a;

  reset_source_controller dut_u (
    .ref_clk(ref_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .supplyAboveRaw(supplyAboveRaw),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .sysClkIn(sysClkIn), .comparatorOutRaw(comparatorOutRaw),
    .watchdogExpired(watchdogExpired), .flashWriteEnable(flashWriteEnable),
    .dataMoveWrite(dataMoveWrite), .codeRead(codeRead), .fetch(fetch),
    .flashSecurityFault(flashSecurityFault), .systemReset(systemReset),
    .watchdogForceOn(watchdogForceOn), .watchdogTick(watchdogTick),
    .supplyMonitorOn(supplyMonitorOn)
  );

  ext_reset_model ext_u (
    .assertReq(pinReq), .pinOe(resetPinOe), .pinOut(resetPinOut), .pinLevel(resetPinIn)
  );

  // ==========================================
  // clocks and run limit
  always #10 ref_clk = ~ref_clk;

  // observed system clock; stopping it provokes the missing-clock detector
  always @(posedge ref_clk) if (clkRun) sysClkIn <= ~sysClkIn;

  // whole run is roughly a thousand cycles; ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  // ==========================================
  // helpers
  task automatic final_report;
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step;
    @(posedge ref_clk);
    #2;
  endtask

  task automatic sfr_write(input logic [7:0] ad, input logic [7:0] d);
    sfrAddr = ad;
    sfrWdata = d;
    sfrWrite = 1'b1;
    step();
    sfrWrite = 1'b0;
    // one idle edge so a following write never re-raises the strobe in the same step
    step();
  endtask

  task automatic sfr_read(input logic [7:0] ad, output logic [7:0] d);
    sfrAddr = ad;
    step();
    d = sfrRdata;
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (systemReset !== 1'b0 && n < 300) begin
      step();
      n++;
    end
    check({7'h00, systemReset}, 8'h00);
  endtask

  function automatic logic [7:0] flag_of(input int k);
    int b;
    case (k)
      0: b = rsc_pkg::BIT_PIN;
      1: b = rsc_pkg::BIT_MISSCLK;
      2: b = rsc_pkg::BIT_CMP;
      3: b = rsc_pkg::BIT_WDOG;
      8: b = rsc_pkg::BIT_SW;
      9: b = rsc_pkg::BIT_POR;
      default: b = rsc_pkg::BIT_FERR;
    endcase
    return 8'h01 << b;
  endfunction

  // k: 0 pin, 1 clock stop, 2 comparator, 3 watchdog, 4-6 flash access, 7 security,
  // 8 software, 9 supply drop
  task automatic cause(input int k, input logic [15:0] adr, input logic hit);
    int n;
    case (k)
      0: pinReq = 1'b1;
      1: clkRun = 1'b0;
      2: comparatorOutRaw = 1'b0;
      3: watchdogExpired = 1'b1;
      4: dataMoveWrite = {1'b1, adr};
      5: codeRead = {1'b1, adr};
      6: fetch = {1'b1, adr};
      7: flashSecurityFault = 1'b1;
      8: sfr_write(rsc_pkg::ADDR_RESET_SRC, 8'h10);
      default: supplyAboveRaw = 1'b0;
    endcase
    step();
    watchdogExpired = 1'b0;
    dataMoveWrite = '0;
    codeRead = '0;
    fetch = '0;
    flashSecurityFault = 1'b0;
    n = 0;
    while (systemReset !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    check({7'h00, systemReset}, {7'h00, hit});
    if (hit) begin
      check({7'h00, resetPinOe}, {7'h00, k == 9});
      check({7'h00, watchdogForceOn}, 8'h01);
    end
    pinReq = 1'b0;
    clkRun = 1'b1;
    comparatorOutRaw = 1'b1;
    supplyAboveRaw = 1'b1;
    wait_run();
    if (hit) begin
      sfr_read(rsc_pkg::ADDR_RESET_SRC, rd);
      check(rd, flag_of(k));
    end
  endtask

  task automatic tick_period;
    int n;
    n = 0;
    while (watchdogTick !== 1'b1 && n < 40) begin
      step();
      n++;
    end
    n = 0;
    do begin
      step();
      n++;
    end while (watchdogTick !== 1'b1 && n < 40);
    check(8'(n), 8'(rsc_pkg::WDOG_DIV));
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    #2;
    srst = 1'b0;
    wait_run();
    sfr_read(rsc_pkg::ADDR_RESET_SRC, rd);
    check(rd, 8'h02);
    sfr_read(rsc_pkg::ADDR_SUPPLY_CTRL, rd);
    check(rd, 8'hC0);
    check({7'h00, supplyMonitorOn}, 8'h01);
    sfr_read(8'h10, rd);
    check(rd, 8'h00);
    tick_period();
    sfr_write(rsc_pkg::ADDR_SUPPLY_CTRL, 8'h3F);
    sfr_read(rsc_pkg::ADDR_SUPPLY_CTRL, rd);
    check(rd, 8'h40);
    check({7'h00, supplyMonitorOn}, 8'h00);
    // selected but switched off: a supply drop must not reset
    sfr_write(rsc_pkg::ADDR_RESET_SRC, 8'h02);
    supplyAboveRaw = 1'b0;
    repeat (6) step();
    check({7'h00, systemReset}, 8'h00);
    sfr_read(rsc_pkg::ADDR_SUPPLY_CTRL, rd);
    check(rd, 8'h00);
    supplyAboveRaw = 1'b1;
    repeat (3) step();
    cause(8, 16'h0000, 1'b1);
    sfr_read(rsc_pkg::ADDR_SUPPLY_CTRL, rd);
    check(rd, 8'h40);
    cause(0, 16'h0000, 1'b1);
    sfr_write(rsc_pkg::ADDR_RESET_SRC, 8'h04);
    sfr_write(rsc_pkg::ADDR_RESET_SRC, 8'h00);
    cause(1, 16'h0000, 1'b0);
    // restarted clock must pass the synchroniser and rearm the one-shot before enabling
    repeat (4) step();
    sfr_write(rsc_pkg::ADDR_RESET_SRC, 8'h04);
    cause(1, 16'h0000, 1'b1);
    cause(2, 16'h0000, 1'b0);
    repeat (4) step();
    // comparator has been high for four cycles, past the synchroniser, so enabling it now is chatter-free
    sfr_write(rsc_pkg::ADDR_RESET_SRC, 8'h20);
    cause(2, 16'h0000, 1'b1);
    cause(3, 16'h0000, 1'b1);
    cause(4, 16'hFFFF, 1'b0);
    flashWriteEnable = 1'b1;
    for (int k = 4; k < 7; k++) begin
      cause(k, rsc_pkg::CODE_LIMIT, 1'b0);
      cause(k, rsc_pkg::CODE_LIMIT + 16'h0001, 1'b1);
    end
    cause(7, 16'h0000, 1'b1);
    repeat (8) begin
      a = 16'($random(seed));
      kk = 4 + int'($unsigned($random(seed)) % 3);
      cause(kk, a, a > rsc_pkg::CODE_LIMIT);
    end
    sfr_write(rsc_pkg::ADDR_SUPPLY_CTRL, 8'h80);
    sfr_write(rsc_pkg::ADDR_RESET_SRC, 8'h02);
    cause(9, 16'h0000, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
